/* File: hw/crms_decode.sv */
// Decode of three four-level selects into a 6-bit voltage code
`timescale 1ns/1ns
module crms_decode import crms_pkg::*; (
  // Three decoded four-level inputs, two bits each
  input wire logic [5:0] sel,
  // Resulting DAC code
  output logic [CODE_W-1:0] code
);
  // Each input contributes two bits; the table is packed directly so
  // every one of the 64 codes stays reachable
  always_comb begin
    code = sel;
  end
endmodule // crms_decode

/* File: hw/crms_pkg.sv */
// Package: constants, codes and states of the core regulator mode sequencer
package crms_pkg;
  // Four-level select input states, decoded by the analog front end
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_REF = 2'h1;
  localparam logic [1:0] LVL_OPEN = 2'h2;
  localparam logic [1:0] LVL_HIGH = 2'h3;
  // DAC code width and the zero target reached by a shutdown ramp
  localparam int CODE_W = 6;
  localparam logic [5:0] CODE_ZERO = 6'h00;
  localparam logic [5:0] CODE_STEP = 6'h01;
  // Delay counts in slew-clock cycles
  localparam int DLY_W = 6;
  localparam logic [5:0] DDO_DELAY = 6'h20;
  localparam logic [5:0] SKIP_DELAY_DEF = 6'h20;
  localparam logic [5:0] DLY_ONE = 6'h01;
  // Interrupt status bit positions
  localparam int EV_W = 3;
  localparam int EV_FAULT = 0;
  localparam int EV_SETTLED = 1;
  localparam int EV_DDO = 2;
  // Register indices
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_CLEAR = 2'h1;
  localparam logic [1:0] REG_ENABLE = 2'h2;
  localparam logic [1:0] REG_STATE = 2'h3;
  // Low-power delay sequencer states
  typedef enum logic [1:0] {
    LP_IDLE = 2'b00,
    LP_WAIT_DDO = 2'b01,
    LP_WAIT_SKIP = 2'b10,
    LP_SKIP = 2'b11
  } crms_lp_t;
endpackage

/* File: hw/crms_sync.sv */
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module crms_sync import crms_pkg::*; #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } crms_sync_t;
  crms_sync_t st_q, st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d = st_q;
    if (ce) begin
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule // crms_sync

/* File: hw/crms_top.sv */
// Mode sequencer of the core regulator controller: code select, slew, delays, faults
// What this block does
// - During power-up the boot select code drives the DAC regardless of others.
// - Outside power-up, suspend request routes the suspend select code to the DAC.
// - Otherwise the 6-bit CPU code sets the target, bit zero least significant.
// - Shutdown falling sets the target to zero; the DAC code ramps down to it at the slew clock rate.
// - In shutdown the low-side gate drive is held high.
// - Shutdown override level disables over/undervoltage protection and clears fault.
// - Deep-sleep low applies the offset from the positive and negative inputs.
// - After deep-sleep transition: driver-disable low in 32 cycles, skip 32 later.
// - After suspend slew: driver-disable low in 32 cycles, skip 32 later.
// - Both delays count slew-rate clock cycles, not switching cycles.
// - Low-side drive is forced high after power-down or any latched fault.
// - A parameter removes the overvoltage fault source only.
// - System power-good falling edge shuts down and sets the fault latch.
// - After a fault, stay off until shutdown toggles or supply drops.
// - Each four-level select arrives as a two-bit decoded state.
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ns
module crms_top import crms_pkg::*; #(
  parameter bit HAS_OVP = 1'b1,
  parameter logic [DLY_W-1:0] SKIP_DELAY = SKIP_DELAY_DEF
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Slew-rate clock from the timing resistor oscillator
  input wire logic slew_clock_resistor,
  // Code selects
  input wire logic [5:0] boot_code_select,
  input wire logic [5:0] suspend_code_select,
  input wire logic [CODE_W-1:0] cpu_voltage_code,
  input wire logic power_up,
  // Mode controls
  input wire logic suspend_request,
  input wire logic deep_sleep_n,
  input wire logic shutdown_n,
  input wire logic shutdown_override,
  input wire logic analog_supply_low,
  // Offset inputs, already resolved to a signed code step count
  input wire logic [CODE_W-1:0] offset_plus_in,
  input wire logic [CODE_W-1:0] offset_minus_in,
  // Fault sources and system power good
  input wire logic overvoltage_fault,
  input wire logic undervoltage_fault,
  input wire logic thermal_fault,
  input wire logic system_power_good,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [EV_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Outputs to DAC, power stage and slaves
  output logic [CODE_W-1:0] dac_code,
  output logic [CODE_W-1:0] offset_code,
  output logic offset_active,
  output logic low_side_gate_drive,
  output logic slave_driver_disable_n,
  output logic skip_allowed,
  output logic regulator_on,
  output logic irq
);
  localparam int NPIN = 10;

  typedef struct packed {
    logic [CODE_W-1:0] dac;
    logic [CODE_W-1:0] ofs;
    logic ofs_on;
    logic slew_prev;
    logic pg_prev;
    logic shutdown_n_prev;
    logic fault;
    crms_lp_t lp;
    logic [DLY_W-1:0] cnt;
    logic ddo_n;
    logic skip;
    logic dl;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] enable;
    logic [7:0] rdata;
    logic irq;
    logic on;
  } crms_top_t;
  crms_top_t st_q, st_d;

  // Every mode pin but power_up, and each fault, power-good and slew pin level, passes two flops before use
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s;
  assign pin_raw = {slew_clock_resistor, suspend_request, deep_sleep_n, shutdown_n,
                    shutdown_override, analog_supply_low, overvoltage_fault,
                    undervoltage_fault, thermal_fault, system_power_good};
  crms_sync #(.W(NPIN)) u_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .d(pin_raw),
    .q(pin_s)
  );
  logic slew_s, sus_s, dslp_n_s, shutdown_n_n_s, ovr_s, vlow_s, ov_s, uv_s, th_s, pg_s;
  assign {slew_s, sus_s, dslp_n_s, shutdown_n_n_s, ovr_s, vlow_s, ov_s, uv_s, th_s, pg_s} = pin_s;

  // Four-level selects decoded to codes
  logic [CODE_W-1:0] boot_code, sus_code;
  crms_decode u_boot_dec (
    .sel(boot_code_select),
    .code(boot_code)
  );
  crms_decode u_sus_dec (
    .sel(suspend_code_select),
    .code(sus_code)
  );

  // Combinational helpers
  logic tick, fault_src, running, lp_mode;
  logic [CODE_W-1:0] target;
  logic [EV_W-1:0] ev;

  always_comb begin
    tick = slew_s && !st_q.slew_prev;
    // Override masks voltage protection; OVP source absent without the option
    fault_src = th_s || (!ovr_s && ((HAS_OVP && ov_s) || uv_s));
    running = shutdown_n_n_s && !st_q.fault;
    // Source priority: boot, then suspend, then CPU code
    if (!running) begin
      target = CODE_ZERO;
    end else if (power_up) begin
      target = boot_code;
    end else if (sus_s) begin
      target = sus_code;
    end else begin
      target = cpu_voltage_code;
    end
    lp_mode = running && (sus_s || !dslp_n_s);
  end

  // Next-state logic
  always_comb begin
    st_d = st_q;
    ev = '0;
    if (ce) begin
      st_d.slew_prev = slew_s;
      st_d.pg_prev = pg_s;
      st_d.shutdown_n_prev = shutdown_n_n_s;
      // Slew one DAC step per slew tick toward the target
      if (tick && st_q.dac != target) begin
        if (st_q.dac < target) begin
          st_d.dac = st_q.dac + CODE_STEP;
        end else begin
          st_d.dac = st_q.dac - CODE_STEP;
        end
      end
      // Deep-sleep offset applied while its input is low
      st_d.ofs_on = !dslp_n_s;
      st_d.ofs = dslp_n_s ? CODE_ZERO : offset_plus_in - offset_minus_in;
      // Fault latch: set wins except override clears; restart needs a toggle or low supply
      if (ovr_s) begin
        st_d.fault = 1'b0;
      end else if (fault_src || (st_q.pg_prev && !pg_s)) begin
        st_d.fault = 1'b1;
        ev[EV_FAULT] = !st_q.fault;
      end else if ((!shutdown_n_n_s && st_q.shutdown_n_prev) || vlow_s) begin
        st_d.fault = 1'b0;
      end
      // Low-side drive held high when off or faulted
      st_d.dl = !shutdown_n_n_s || st_d.fault;
      // Kept as its own flop so the pin is not an inverter output
      st_d.on = !st_d.dl;
      // Low-power delay sequencer, counted in slew ticks
      case (st_q.lp)
        LP_IDLE: begin
          if (lp_mode && st_q.dac == target) begin
            st_d.lp = LP_WAIT_DDO;
            st_d.cnt = DDO_DELAY;
            ev[EV_SETTLED] = 1'b1;
          end
        end
        LP_WAIT_DDO: begin
          if (tick) begin
            st_d.cnt = st_q.cnt - DLY_ONE;
            if (st_q.cnt == DLY_ONE) begin
              st_d.ddo_n = 1'b0;
              st_d.lp = LP_WAIT_SKIP;
              st_d.cnt = SKIP_DELAY;
              ev[EV_DDO] = 1'b1;
            end
          end
        end
        LP_WAIT_SKIP: begin
          if (tick) begin
            st_d.cnt = st_q.cnt - DLY_ONE;
            if (st_q.cnt == DLY_ONE) begin
              st_d.skip = 1'b1;
              st_d.lp = LP_SKIP;
            end
          end
        end
        LP_SKIP: begin
        end
        default: begin
          st_d.lp = LP_IDLE;
        end
      endcase
      // Leaving suspend or deep-sleep releases at once, as does a new target slew
      if (!lp_mode || st_q.dac != target) begin
        st_d.lp = LP_IDLE;
        st_d.ddo_n = 1'b1;
        st_d.skip = 1'b0;
        st_d.cnt = '0;
      end
      // Register port: set wins over clear
      if (reg_wr && reg_addr == REG_CLEAR) begin
        st_d.status = st_q.status & ~reg_wdata;
      end
      if (reg_wr && reg_addr == REG_ENABLE) begin
        st_d.enable = reg_wdata;
      end
      st_d.status = st_d.status | ev;
      st_d.rdata = '0;
      if (reg_rd) begin
        case (reg_addr)
          REG_STATUS: st_d.rdata = {5'h0_0, st_q.status};
          REG_ENABLE: st_d.rdata = {5'h0_0, st_q.enable};
          REG_STATE: st_d.rdata = {st_q.fault, st_q.ddo_n, st_q.skip, st_q.lp, 3'h0};
          default: st_d.rdata = '0;
        endcase
      end
      st_d.irq = |(st_d.status & st_d.enable);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
      st_q.ddo_n <= 1'b1;
      st_q.dl <= 1'b1;
      st_q.shutdown_n_prev <= 1'b0;
      st_q.lp <= LP_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign dac_code = st_q.dac;
  assign offset_code = st_q.ofs;
  assign offset_active = st_q.ofs_on;
  assign low_side_gate_drive = st_q.dl;
  assign slave_driver_disable_n = st_q.ddo_n;
  assign skip_allowed = st_q.skip;
  assign regulator_on = st_q.on;
  assign irq = st_q.irq;
  assign reg_rdata = st_q.rdata;

  // Skip never granted while slave drivers are still enabled
  a_skip_after_ddo: assert property (@(posedge clk) disable iff (reset)
    st_q.skip |-> !st_q.ddo_n) else $error("skip without driver disable");
  a_dl_when_fault: assert property (@(posedge clk) disable iff (reset)
    st_q.fault |-> st_q.dl) else $error("low side not forced on fault");
  a_dac_one_step: assert property (@(posedge clk) disable iff (reset)
    (st_q.dac != $past(st_q.dac)) |-> (st_q.dac - $past(st_q.dac) == CODE_STEP
      || $past(st_q.dac) - st_q.dac == CODE_STEP)) else $error("slew jumped");
  a_pg_fall_fault: assert property (@(posedge clk) disable iff (reset)
    (ce && st_q.pg_prev && !pg_s && !ovr_s) |=> st_q.fault)
    else $error("power good fall missed");
  a_override_clear: assert property (@(posedge clk) disable iff (reset)
    (ce && ovr_s) |=> !st_q.fault) else $error("override left fault");
  a_leave_release: assert property (@(posedge clk) disable iff (reset)
    (ce && !lp_mode) |=> (st_q.ddo_n && !st_q.skip)) else $error("not released");
  a_shutdown_n_dl: assert property (@(posedge clk) disable iff (reset)
    (ce && !shutdown_n_n_s) |=> st_q.dl) else $error("shutdown dl low");
  a_ddo_needs_tick: assert property (@(posedge clk) disable iff (reset)
    $fell(st_q.ddo_n) |-> $past(tick)) else $error("ddo fell off tick");
  // Skip grant also only advances on a slew tick
  a_skip_needs_tick: assert property (@(posedge clk) disable iff (reset)
    $rose(st_q.skip) |-> $past(tick)) else $error("skip rose off tick");
  // Shutdown ramps down one step per tick, never jumps to zero
  a_off_ramp_down: assert property (@(posedge clk) disable iff (reset)
    (ce && !running && tick && st_q.dac != CODE_ZERO) |=>
      (st_q.dac == $past(st_q.dac) - CODE_STEP)) else $error("no ramp down");
  // Boot code wins while powering up
  a_boot_source: assert property (@(posedge clk) disable iff (reset)
    (ce && running && power_up && tick && st_q.dac < boot_code) |=>
      (st_q.dac == $past(st_q.dac) + CODE_STEP)) else $error("boot not tracked");
  // Suspend code wins outside power-up
  a_sus_source: assert property (@(posedge clk) disable iff (reset)
    (ce && running && !power_up && sus_s && tick && st_q.dac > sus_code) |=>
      (st_q.dac == $past(st_q.dac) - CODE_STEP)) else $error("suspend not tracked");
  // CPU code otherwise
  a_cpu_source: assert property (@(posedge clk) disable iff (reset)
    (ce && running && !power_up && !sus_s && tick && st_q.dac < cpu_voltage_code) |=>
      (st_q.dac == $past(st_q.dac) + CODE_STEP)) else $error("cpu code not tracked");
  // Offset follows the synchronised deep-sleep level
  a_ofs_follow: assert property (@(posedge clk) disable iff (reset)
    (ce && !dslp_n_s) |=> st_q.ofs_on) else $error("offset not applied");
  // Low supply restarts a latched fault when no source is active
  a_vlow_clear: assert property (@(posedge clk) disable iff (reset)
    (ce && vlow_s && !ovr_s && !fault_src && !(st_q.pg_prev && !pg_s)) |=> !st_q.fault)
    else $error("supply drop left fault");
endmodule // crms_top

/* File: testbench/crms_partner.sv */
// Far-side model: slew oscillator, rail power-good node and slave driver
`timescale 1ns/1ns
module crms_partner #(
  parameter int HALF = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Rails and slave control
  input wire logic [1:0] rail_low,
  input wire logic slave_driver_disable_n,
  output logic system_power_good,
  output logic slave_gate_oe,
  output logic slew_clock_resistor
);
  int cnt;
  // Free-running oscillator, far faster than real so delay counts stay short
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt <= 0;
      slew_clock_resistor <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      slew_clock_resistor <= ~slew_clock_resistor;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Any rail pulling its open-drain output low drags the shared node low
  assign system_power_good = ~|rail_low;
  // Slave drivers float while disabled, leaving the master to skip alone
  assign slave_gate_oe = slave_driver_disable_n;
endmodule // crms_partner

/* File: testbench/crms_top_tb.sv */
// Self-checking bench of the core regulator mode sequencer
`timescale 1ns/1ns
module crms_top_tb;
  import crms_pkg::*;
  localparam logic [DLY_W-1:0] SKIP_T = 6'h1e;
  logic clk, reset, slew, power_up, suspend_request, deep_sleep_n, shutdown_n, ovr;
  logic ov_f, uv_f, th_f, pg, reg_wr, reg_rd, irq, dl, ddo_n, skip, on, off_act, slave_oe;
  logic ce, vlow;
  logic [1:0] reg_addr, rail_low;
  logic [2:0] reg_wdata;
  logic [5:0] boot_sel, sus_sel, cpu, off_p, off_m, dac, off_code;
  logic [7:0] reg_rdata, rd;
  int errors, checks, n;
  crms_top #(.HAS_OVP(1'b1), .SKIP_DELAY(SKIP_T)) u_crms_top (
    .clk(clk), .reset(reset), .ce(ce), .slew_clock_resistor(slew),
    .boot_code_select(boot_sel), .suspend_code_select(sus_sel), .cpu_voltage_code(cpu),
    .power_up(power_up), .suspend_request(suspend_request), .deep_sleep_n(deep_sleep_n),
    .shutdown_n(shutdown_n), .shutdown_override(ovr), .analog_supply_low(vlow),
    .offset_plus_in(off_p), .offset_minus_in(off_m), .overvoltage_fault(ov_f),
    .undervoltage_fault(uv_f), .thermal_fault(th_f), .system_power_good(pg),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dac_code(dac), .offset_code(off_code), .offset_active(off_act),
    .low_side_gate_drive(dl), .slave_driver_disable_n(ddo_n), .skip_allowed(skip),
    .regulator_on(on), .irq(irq));
  crms_partner u_crms_partner (.clk(clk), .reset(reset), .rail_low(rail_low),
    .slave_driver_disable_n(ddo_n), .system_power_good(pg), .slave_gate_oe(slave_oe),
    .slew_clock_resistor(slew));
  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic results();
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Tick counts carry one tick of slack for the pin synchroniser
  task automatic near(input int v, input int e);
    chk(8'((v >= e - 1 && v <= e + 1) ? e : v), 8'(e));
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic reg_write(input logic [1:0] a, input logic [2:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic wait_dac(input logic [5:0] v);
    int i;
    for (i = 0; i < 3000 && dac !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk({2'h0, dac}, {2'h0, v});
    if (i == 3000) results();
  endtask
  // Counts raw slew edges until disable falls or skip is granted
  task automatic ticks(input bit for_skip, output int t);
    int i;
    logic p;
    t = 0;
    p = slew;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      if (slew && !p) t++;
      p = slew;
      if (for_skip ? skip === 1'b1 : ddo_n === 1'b0) break;
    end
    if (i == 3000) begin
      errors++;
      results();
    end
  endtask
  task automatic boot_then_active();
    chk({dac, ddo_n, dl}, 8'h03);
    chk({6'h0, skip, irq}, 8'h00);
    cyc(8);
    chk({7'h0, dac == 6'h27}, 8'h00);
    wait_dac(6'h27);
    chk({7'h0, on}, 8'h01);
    power_up <= 1'b0;
    wait_dac(6'h3f);
  endtask
  task automatic suspend_seq();
    reg_write(REG_ENABLE, 3'h4);
    suspend_request <= 1'b1;
    wait_dac(6'h09);
    ticks(1'b0, n);
    near(n, 32);
    cyc(2);
    chk({7'h0, irq}, 8'h01);
    ticks(1'b1, n);
    near(n, 30);
    reg_read(REG_ENABLE);
    chk(rd, 8'h04);
    reg_read(REG_CLEAR);
    chk(rd, 8'h00);
    reg_write(REG_CLEAR, 3'h4);
    cyc(2);
    chk({7'h0, irq}, 8'h00);
    suspend_request <= 1'b0;
    cyc(6);
    chk({6'h0, skip, ddo_n}, 8'h01);
    wait_dac(6'h3f);
  endtask
  task automatic deep_sleep_seq();
    deep_sleep_n <= 1'b0;
    ticks(1'b0, n);
    near(n, 32);
    chk({off_code, off_act, 1'b0}, 8'h0e);
    ticks(1'b1, n);
    near(n, 30);
    cyc(1);
    reg_read(REG_STATE);
    chk(rd, 8'h38);
    chk({7'h0, slave_oe}, 8'h00);
    deep_sleep_n <= 1'b1;
    cyc(6);
    chk({5'h0, off_act, skip, ddo_n}, 8'h01);
  endtask
  task automatic shutdown_seq();
    shutdown_n <= 1'b0;
    cyc(6);
    chk({7'h0, dac == CODE_ZERO}, 8'h00);
    // Enable low must freeze the ramp
    ce <= 1'b0;
    cyc(2);
    rd = {2'h0, dac};
    cyc(24);
    chk({2'h0, dac}, rd);
    ce <= 1'b1;
    wait_dac(CODE_ZERO);
    chk({6'h0, dl, on}, 8'h02);
    shutdown_n <= 1'b1;
    wait_dac(6'h3f);
  endtask
  task automatic fault_seq();
    for (int k = 0; k < 4; k++) begin
      ov_f <= (k == 0);
      uv_f <= (k == 1);
      th_f <= (k == 2);
      rail_low <= (k == 3) ? 2'h2 : 2'h0;
      cyc(6);
      chk({6'h0, dl, on}, 8'h02);
      reg_read(REG_STATUS);
      chk(rd & 8'h01, 8'h01);
      {ov_f, uv_f, th_f} <= 3'h0;
      rail_low <= 2'h0;
      cyc(6);
      chk({7'h0, on}, 8'h00);
      reg_write(REG_CLEAR, 3'h1);
      shutdown_n <= 1'b0;
      cyc(6);
      shutdown_n <= 1'b1;
      cyc(6);
      chk({7'h0, on}, 8'h01);
    end
    uv_f <= 1'b1;
    cyc(6);
    chk({7'h0, on}, 8'h00);
    ovr <= 1'b1;
    cyc(6);
    chk({7'h0, on}, 8'h01);
    uv_f <= 1'b0;
    ovr <= 1'b0;
    cyc(6);
    // Restart by a supply drop instead of a shutdown toggle
    th_f <= 1'b1;
    cyc(6);
    chk({7'h0, on}, 8'h00);
    th_f <= 1'b0;
    cyc(6);
    chk({7'h0, on}, 8'h00);
    vlow <= 1'b1;
    cyc(6);
    vlow <= 1'b0;
    cyc(6);
    chk({7'h0, on}, 8'h01);
  endtask
  // Sequence: reset, then each mode in turn
  initial begin
    {errors, checks} = 0;
    {reset, power_up, shutdown_n, deep_sleep_n} = 4'hf;
    {suspend_request, ovr, ov_f, uv_f, th_f, reg_wr, reg_rd} = 7'h00;
    {reg_addr, rail_low, reg_wdata} = 7'h00;
    {ce, vlow} = 2'h2;
    boot_sel = {LVL_OPEN, LVL_REF, LVL_HIGH};
    sus_sel = {LVL_LOW, LVL_OPEN, LVL_REF};
    {cpu, off_p, off_m} = {6'h3f, 6'h05, 6'h02};
    cyc(4);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    boot_then_active();
    suspend_seq();
    deep_sleep_seq();
    shutdown_seq();
    fault_seq();
    results();
  end
endmodule // crms_top_tb
